// ---- fanpw_params.svh ----
// Offsets, field positions, reset values and timing counts of the fan ramp block
`ifndef FANPW_PARAMS_SVH
`define FANPW_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FANPW_ADDR_SMOOTH 8'h62
`define FANPW_ADDR_BELOW_START_HOLD_ONE 8'h64
`define FANPW_ADDR_MIN2 8'h65
`define FANPW_ADDR_MIN3 8'h66
`define FANPW_ADDR_APPLIED1 8'ha0
`define FANPW_ADDR_APPLIED2 8'ha1
`define FANPW_ADDR_APPLIED3 8'ha2

// ----------------------------------------
// Field positions, reset values and duty limits
// ----------------------------------------
`define FANPW_THIRD_RATE_LSB 0
`define FANPW_THIRD_ON_BIT 3
`define FANPW_SECOND_RATE_LSB 4
`define FANPW_SECOND_ON_BIT 7
`define FANPW_SMOOTH_RST 8'h00
`define FANPW_MIN_RST 8'h80
`define FANPW_DUTY_OFF 8'h00
`define FANPW_DUTY_FULL 8'hff

// ----------------------------------------
// Step per time slot for each rate code
// ----------------------------------------
`define FANPW_STEP0 8'd1
`define FANPW_STEP1 8'd2
`define FANPW_STEP2 8'd3
`define FANPW_STEP3 8'd5
`define FANPW_STEP4 8'd8
`define FANPW_STEP5 8'd12
`define FANPW_STEP6 8'd24
`define FANPW_STEP7 8'd48

// ----------------------------------------
// Timing
// ----------------------------------------
`define FANPW_CLK_KHZ 64'd200000
`define FANPW_RAMP_FULL_MS 64'd35000
`define FANPW_RAMP_SPAN 64'd171
`define FANPW_SLOT_CYCLES (`FANPW_RAMP_FULL_MS * `FANPW_CLK_KHZ / `FANPW_RAMP_SPAN)
`define FANPW_PWM_PRESCALE 30

`endif

// ---- fanpw_pkg.sv ----
// Types shared by the fan ramp block
`default_nettype none
package fanpw_pkg;
  typedef logic [7:0] fanpw_duty_t;
  typedef logic [2:0] fanpw_rate_t;
  typedef enum {FANPW_SRC_MANUAL, FANPW_SRC_AUTO, FANPW_SRC_OFF, FANPW_SRC_FLOOR} fanpw_src_e;
  typedef enum {FANPW_HOLD, FANPW_RISE, FANPW_FALL} fanpw_dir_e;
endpackage
`default_nettype wire

// ---- fanpw_ramp.sv ----
// Duty smoother that steps one output toward its target once per time slot
`timescale 1ns/1ps
`default_nettype none
`include "fanpw_params.svh"
module fanpw_ramp (
  input wire logic clk,
  input wire logic rst,
  input wire logic smooth_on,
  input wire fanpw_pkg::fanpw_rate_t rate,
  input wire fanpw_pkg::fanpw_duty_t target,
  input wire logic slot_tick,
  output fanpw_pkg::fanpw_duty_t duty
);
  import fanpw_pkg::*;

  // ----------------------------------------
  // Step decode
  // ----------------------------------------
  function automatic fanpw_duty_t step_of(input fanpw_rate_t code);
    case (code)
      3'h0: step_of = `FANPW_STEP0;
      3'h1: step_of = `FANPW_STEP1;
      3'h2: step_of = `FANPW_STEP2;
      3'h3: step_of = `FANPW_STEP3;
      3'h4: step_of = `FANPW_STEP4;
      3'h5: step_of = `FANPW_STEP5;
      3'h6: step_of = `FANPW_STEP6;
      default: step_of = `FANPW_STEP7;
    endcase
  endfunction

  fanpw_dir_e dir;
  fanpw_duty_t step;
  fanpw_duty_t gap_up;
  fanpw_duty_t gap_down;
  fanpw_duty_t next_duty;

  assign step = step_of(rate);
  assign gap_up = target - duty;
  assign gap_down = duty - target;
  assign dir = (target > duty) ? FANPW_RISE : (target < duty) ? FANPW_FALL : FANPW_HOLD;

  always_comb begin
    next_duty = duty;
    if (!smooth_on) begin
      next_duty = target;
    end else if (slot_tick) begin
      case (dir)
        FANPW_RISE: next_duty = (gap_up <= step) ? target : duty + step;
        FANPW_FALL: next_duty = (gap_down <= step) ? target : duty - step;
        FANPW_HOLD: next_duty = duty;
        default: next_duty = duty;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      duty <= `FANPW_DUTY_OFF;
    end else begin
      duty <= next_duty;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_direct_apply: assert property (@(posedge clk) disable iff (rst)
    !smooth_on |=> duty == $past(target))
    else $error("Unsmoothed duty did not follow target");
  a_step_bound: assert property (@(posedge clk) disable iff (rst)
    smooth_on && slot_tick |=> ((duty >= $past(duty)) ? (duty - $past(duty))
      : ($past(duty) - duty)) <= step_of($past(rate)))
    else $error("Duty moved more than one step");
  a_no_overshoot: assert property (@(posedge clk) disable iff (rst)
    smooth_on && slot_tick && duty < target |=> duty > $past(duty) && duty <= $past(target))
    else $error("Rising duty overshot or stalled");
  a_idle_hold: assert property (@(posedge clk) disable iff (rst)
    smooth_on && !slot_tick |=> duty == $past(duty))
    else $error("Smoothed duty moved between slots");
endmodule
`default_nettype wire

// ---- fanpw_gen.sv ----
// Duty-cycle pulse generator for one fan drive output
`timescale 1ns/1ps
`default_nettype none
`include "fanpw_params.svh"
module fanpw_gen #(
  parameter int unsigned PRESCALE = `FANPW_PWM_PRESCALE
) (
  input wire logic clk,
  input wire logic rst,
  input wire fanpw_pkg::fanpw_duty_t duty,
  output logic drive
);
  import fanpw_pkg::*;

  logic [15:0] pre_cnt;
  fanpw_duty_t phase;
  logic pre_wrap;

  assign pre_wrap = (pre_cnt == 16'(PRESCALE - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt <= 16'h0000;
      phase <= 8'h00;
      drive <= 1'b0;
    end else begin
      pre_cnt <= pre_wrap ? 16'h0000 : pre_cnt + 16'h0001;
      phase <= pre_wrap ? phase + 8'h01 : phase;
      drive <= (duty == `FANPW_DUTY_FULL) || (phase < duty);
    end
  end

  a_full_drive: assert property (@(posedge clk) disable iff (rst)
    duty == `FANPW_DUTY_FULL |=> drive)
    else $error("Full duty did not hold the drive high");
  a_off_drive: assert property (@(posedge clk) disable iff (rst)
    duty == `FANPW_DUTY_OFF |=> !drive)
    else $error("Zero duty let the drive go high");
endmodule
`default_nettype wire

// ---- fanpw_top.sv ----
// Fan ramp smoothing and minimum duty block with register port and three drives
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fanpw_params.svh"
module fanpw_top #(
  parameter int unsigned SLOT_CYCLES = 32'(`FANPW_SLOT_CYCLES),
  parameter int unsigned PWM_PRESCALE = `FANPW_PWM_PRESCALE
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic AUTO_MODE,
  input wire fanpw_pkg::fanpw_duty_t CALC_DUTY_ONE,
  input wire fanpw_pkg::fanpw_duty_t CALC_DUTY_TWO,
  input wire fanpw_pkg::fanpw_duty_t CALC_DUTY_THREE,
  input wire logic [2:0] BELOW_START,
  input wire logic [2:0] BELOW_START_HOLD,
  output logic FAN_DRIVE_ONE,
  output logic FAN_DRIVE_TWO,
  output logic FAN_DRIVE_THREE
);
  import fanpw_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] smooth_ctrl;
  fanpw_duty_t minimum_duty [3];
  logic [31:0] slot_cnt;
  logic slot_tick;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic [2:0] hit3(input logic [7:0] addr, input logic [7:0] base);
    hit3 = {addr == base + 8'h02, addr == base + 8'h01, addr == base};
  endfunction

  wire hit_smooth;
  wire [2:0] hit_min;
  wire [2:0] hit_applied;
  wire wr_smooth;
  wire [2:0] wr_min;

  assign hit_smooth = (REG_ADDR == `FANPW_ADDR_SMOOTH);
  assign hit_min = hit3(REG_ADDR, `FANPW_ADDR_BELOW_START_HOLD_ONE);
  assign hit_applied = hit3(REG_ADDR, `FANPW_ADDR_APPLIED1);
  assign wr_smooth = REG_WR && hit_smooth;
  assign wr_min = (REG_WR && !AUTO_MODE) ? hit_min : 3'b000;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  wire fanpw_rate_t third_output_ramp_rate;
  wire fanpw_rate_t second_output_ramp_rate;
  wire third_output_smooth_on;
  wire second_output_smooth_on;

  assign third_output_ramp_rate = smooth_ctrl[`FANPW_THIRD_RATE_LSB +: 3];
  assign third_output_smooth_on = smooth_ctrl[`FANPW_THIRD_ON_BIT];
  assign second_output_ramp_rate = smooth_ctrl[`FANPW_SECOND_RATE_LSB +: 3];
  assign second_output_smooth_on = smooth_ctrl[`FANPW_SECOND_ON_BIT];

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      smooth_ctrl <= `FANPW_SMOOTH_RST;
    end else if (wr_smooth) begin
      smooth_ctrl <= REG_WDATA;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_min
      always_ff @(posedge CLK_SYS) begin
        if (RST) begin
          minimum_duty[g] <= `FANPW_MIN_RST;
        end else if (wr_min[g]) begin
          minimum_duty[g] <= REG_WDATA;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Time slot
  // ----------------------------------------
  assign slot_tick = (slot_cnt == SLOT_CYCLES - 32'd1);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      slot_cnt <= 32'h00000000;
    end else begin
      slot_cnt <= slot_tick ? 32'h00000000 : slot_cnt + 32'h00000001;
    end
  end

  // ----------------------------------------
  // Duty source per output
  // ----------------------------------------
  fanpw_duty_t calc_duty [3];
  fanpw_duty_t cmd_duty [3];
  fanpw_duty_t applied_duty [3];
  fanpw_src_e src [3];
  logic smooth_on [3];
  fanpw_rate_t ramp_rate [3];
  logic drive [3];

  assign calc_duty[0] = CALC_DUTY_ONE;
  assign calc_duty[1] = CALC_DUTY_TWO;
  assign calc_duty[2] = CALC_DUTY_THREE;
  assign smooth_on[0] = 1'b0;
  assign smooth_on[1] = second_output_smooth_on;
  assign smooth_on[2] = third_output_smooth_on;
  assign ramp_rate[0] = 3'h0;
  assign ramp_rate[1] = second_output_ramp_rate;
  assign ramp_rate[2] = third_output_ramp_rate;

  generate
    for (g = 0; g < 3; g++) begin : g_out
      always_comb begin
        if (!AUTO_MODE) begin
          src[g] = FANPW_SRC_MANUAL;
        end else if (!BELOW_START[g]) begin
          src[g] = FANPW_SRC_AUTO;
        end else if (BELOW_START_HOLD[g]) begin
          src[g] = FANPW_SRC_FLOOR;
        end else begin
          src[g] = FANPW_SRC_OFF;
        end
      end

      always_comb begin
        case (src[g])
          FANPW_SRC_MANUAL: cmd_duty[g] = calc_duty[g];
          FANPW_SRC_AUTO: cmd_duty[g] = calc_duty[g];
          FANPW_SRC_FLOOR: cmd_duty[g] = minimum_duty[g];
          FANPW_SRC_OFF: cmd_duty[g] = `FANPW_DUTY_OFF;
          default: cmd_duty[g] = `FANPW_DUTY_OFF;
        endcase
      end

      fanpw_ramp u_ramp (
        .clk(CLK_SYS),
        .rst(RST),
        .smooth_on(smooth_on[g]),
        .rate(ramp_rate[g]),
        .target(cmd_duty[g]),
        .slot_tick(slot_tick),
        .duty(applied_duty[g])
      );

      fanpw_gen #(
        .PRESCALE(PWM_PRESCALE)
      ) u_gen (
        .clk(CLK_SYS),
        .rst(RST),
        .duty(applied_duty[g]),
        .drive(drive[g])
      );
    end
  endgenerate

  assign FAN_DRIVE_ONE = drive[0];
  assign FAN_DRIVE_TWO = drive[1];
  assign FAN_DRIVE_THREE = drive[2];

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  wire [7:0] read_sel;
  wire [7:0] next_rdata;

  assign read_sel = hit_smooth ? smooth_ctrl :
                    hit_min[0] ? minimum_duty[0] :
                    hit_min[1] ? minimum_duty[1] :
                    hit_min[2] ? minimum_duty[2] :
                    hit_applied[0] ? applied_duty[0] :
                    hit_applied[1] ? applied_duty[1] :
                    hit_applied[2] ? applied_duty[2] : 8'h00;
  assign next_rdata = REG_RD ? read_sel : 8'h00;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_smooth_reset: assert property (@(posedge CLK_SYS)
    RST |=> smooth_ctrl == `FANPW_SMOOTH_RST && !second_output_smooth_on
      && !third_output_smooth_on)
    else $error("Smoothing control not cleared by reset");
  a_min_reset: assert property (@(posedge CLK_SYS)
    RST |=> minimum_duty[0] == 8'h80 && minimum_duty[1] == 8'h80 && minimum_duty[2] == 8'h80)
    else $error("Minimum duty not at half after reset");
  a_min_write_lock: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_WR && AUTO_MODE && REG_ADDR == `FANPW_ADDR_MIN2
      |=> minimum_duty[1] == $past(minimum_duty[1]))
    else $error("Minimum duty changed in automatic mode");
  a_min_write_take: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_WR && !AUTO_MODE && REG_ADDR == `FANPW_ADDR_MIN3
      |=> minimum_duty[2] == $past(REG_WDATA) ##1 REG_RD && REG_ADDR == `FANPW_ADDR_MIN3
      |=> REG_RDATA == minimum_duty[2])
    else $error("Minimum duty write not taken or not read back");
  a_floor_off: assert property (@(posedge CLK_SYS) disable iff (RST)
    AUTO_MODE && BELOW_START[0] && !BELOW_START_HOLD[0] |=> applied_duty[0] == 8'h00)
    else $error("Output one not off below start");
  a_floor_min: assert property (@(posedge CLK_SYS) disable iff (RST)
    AUTO_MODE && BELOW_START[0] && BELOW_START_HOLD[0]
      |=> applied_duty[0] == $past(minimum_duty[0]))
    else $error("Output one not at minimum below start");
  a_ctrl_readback: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_RD && REG_ADDR == `FANPW_ADDR_SMOOTH |=> REG_RDATA == $past(smooth_ctrl))
    else $error("Smoothing control read back wrong");
  a_read_idle_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
    !REG_RD |=> REG_RDATA == 8'h00)
    else $error("Read data not zero outside a read");
  a_slot_period: assert property (@(posedge CLK_SYS) disable iff (RST)
    slot_tick |=> !slot_tick && slot_cnt == 32'd0)
    else $error("Time slot counter did not restart");

  a_slot_count: assert property (@(posedge CLK_SYS) disable iff (RST)
    !slot_tick |=> slot_cnt == $past(slot_cnt) + 32'd1)
    else $error("Time slot counter did not advance");

  // ----------------------------------------
  // Control field and readback checks
  // ----------------------------------------
  a_third_rate_take: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_WR && REG_ADDR == `FANPW_ADDR_SMOOTH
      |=> third_output_ramp_rate == $past(REG_WDATA[`FANPW_THIRD_RATE_LSB +: 3]))
    else $error("Third output rate field not written");

  a_third_on_take: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_WR && REG_ADDR == `FANPW_ADDR_SMOOTH
      |=> third_output_smooth_on == $past(REG_WDATA[`FANPW_THIRD_ON_BIT]))
    else $error("Third output enable bit not written");

  a_second_rate_take: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_WR && REG_ADDR == `FANPW_ADDR_SMOOTH
      |=> second_output_ramp_rate == $past(REG_WDATA[`FANPW_SECOND_RATE_LSB +: 3]))
    else $error("Second output rate field not written");

  a_second_on_take: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_WR && REG_ADDR == `FANPW_ADDR_SMOOTH
      |=> second_output_smooth_on == $past(REG_WDATA[`FANPW_SECOND_ON_BIT]))
    else $error("Second output enable bit not written");

  a_min_readback: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_RD && REG_ADDR == `FANPW_ADDR_BELOW_START_HOLD_ONE |=> REG_RDATA == $past(minimum_duty[0]))
    else $error("Minimum duty one read back wrong");

  a_applied_readback: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_RD && REG_ADDR == `FANPW_ADDR_APPLIED3 |=> REG_RDATA == $past(applied_duty[2]))
    else $error("Applied duty three read back wrong");

  // ----------------------------------------
  // Lock and source checks
  // ----------------------------------------
  a_min_one_lock: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_WR && AUTO_MODE && REG_ADDR == `FANPW_ADDR_BELOW_START_HOLD_ONE
      |=> minimum_duty[0] == $past(minimum_duty[0]))
    else $error("Minimum duty one changed in automatic mode");

  a_min_three_lock: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_WR && AUTO_MODE && REG_ADDR == `FANPW_ADDR_MIN3
      |=> minimum_duty[2] == $past(minimum_duty[2]))
    else $error("Minimum duty three changed in automatic mode");

  a_one_direct: assert property (@(posedge CLK_SYS) disable iff (RST)
    !AUTO_MODE |=> applied_duty[0] == $past(CALC_DUTY_ONE))
    else $error("Output one did not follow its duty");

  a_two_direct: assert property (@(posedge CLK_SYS) disable iff (RST)
    !AUTO_MODE && !second_output_smooth_on |=> applied_duty[1] == $past(CALC_DUTY_TWO))
    else $error("Unsmoothed output two did not follow its duty");

  a_three_direct: assert property (@(posedge CLK_SYS) disable iff (RST)
    !AUTO_MODE && !third_output_smooth_on |=> applied_duty[2] == $past(CALC_DUTY_THREE))
    else $error("Unsmoothed output three did not follow its duty");

  a_auto_follow: assert property (@(posedge CLK_SYS) disable iff (RST)
    AUTO_MODE && !BELOW_START[0] |=> applied_duty[0] == $past(CALC_DUTY_ONE))
    else $error("Output one not at its duty above start");

  a_two_floor_off: assert property (@(posedge CLK_SYS) disable iff (RST)
    AUTO_MODE && BELOW_START[1] && !BELOW_START_HOLD[1] && !second_output_smooth_on
      |=> applied_duty[1] == 8'h00)
    else $error("Output two not off below start");

  a_three_floor_min: assert property (@(posedge CLK_SYS) disable iff (RST)
    AUTO_MODE && BELOW_START[2] && BELOW_START_HOLD[2] && !third_output_smooth_on
      |=> applied_duty[2] == $past(minimum_duty[2]))
    else $error("Output three not at minimum below start");

  a_two_tick_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    second_output_smooth_on && !slot_tick |=> applied_duty[1] == $past(applied_duty[1]))
    else $error("Smoothed output two moved between slots");
endmodule
`default_nettype wire

// ---- fanpw_fan_model.sv ----
// Fan model that measures the duty seen on one drive output
`timescale 1ns/1ps
`default_nettype none
module fanpw_fan_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic drive,
  output logic [8:0] high_cnt
);
  // ----------------------------------------
  // Duty measurement over 256-cycle windows
  // ----------------------------------------
  logic [7:0] slot;
  logic [8:0] acc;
  always_ff @(posedge clk) begin
    if (rst) begin
      slot <= 8'h00;
      acc <= 9'h000;
      high_cnt <= 9'h000;
    end else begin
      slot <= slot + 8'h01;
      acc <= (slot == 8'hff) ? 9'h000 : acc + {8'h00, drive};
      if (slot == 8'hff) begin
        high_cnt <= acc + {8'h00, drive};
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb_fanpw_top.sv ----
// Self-checking testbench for the fan ramp smoothing block
`timescale 1ns/1ps
`default_nettype none
module tb_fanpw_top;
  import fanpw_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic auto_mode = 1'b0;
  fanpw_duty_t calc [3] = '{8'h00, 8'h00, 8'h00};
  logic [2:0] below = 3'h0;
  logic [2:0] hold = 3'h0;
  logic [2:0] drives;
  logic [26:0] meas;
  logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h18, 8'h30};
  logic [7:0] duties [4] = '{8'h00, 8'h40, 8'h80, 8'hff};
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  fanpw_top #(.SLOT_CYCLES(8), .PWM_PRESCALE(1)) u_fanpw_top (
    .CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .AUTO_MODE(auto_mode),
    .CALC_DUTY_ONE(calc[0]), .CALC_DUTY_TWO(calc[1]), .CALC_DUTY_THREE(calc[2]),
    .BELOW_START(below), .BELOW_START_HOLD(hold), .FAN_DRIVE_ONE(drives[0]),
    .FAN_DRIVE_TWO(drives[1]), .FAN_DRIVE_THREE(drives[2]));
  fanpw_fan_model u_fanpw_fan_model [2:0] (
    .clk(clk_sys), .rst(rst), .drive(drives), .high_cnt(meas));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    chk({1'b0, d}, {1'b0, e});
  endtask
  task automatic ramp_to(input int sel, input logic [7:0] tgt, input logic [7:0] step);
    logic [7:0] prev;
    logic [7:0] cur;
    logic [7:0] gap;
    calc[sel-1] <= tgt;
    rd_reg(8'h9f + 8'(sel), prev);
    for (int n = 0; n < 1000 && prev !== tgt; n++) begin
      rd_reg(8'h9f + 8'(sel), cur);
      if (cur !== prev) begin
        gap = (tgt > prev) ? tgt - prev : prev - tgt;
        if (gap > step) gap = step;
        chk({1'b0, cur}, {1'b0, (tgt > prev) ? prev + gap : prev - gap});
        prev = cur;
      end
    end
    chk({1'b0, prev}, {1'b0, tgt});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk(8'h62, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rd_chk(8'h64 + 8'(i), 8'h80);
      rd_chk(8'ha0 + 8'(i), 8'h00);
    end
  endtask
  task automatic t_regs;
    wr_reg(8'h62, 8'h5a);
    rd_chk(8'h62, 8'h5a);
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h64 + 8'(i), 8'h3c + 8'(i) * 8'h1e);
      rd_chk(8'h64 + 8'(i), 8'h3c + 8'(i) * 8'h1e);
    end
    wr_reg(8'ha0, 8'h55);
    rd_chk(8'ha0, 8'h00);
    rd_chk(8'h70, 8'h00);
    wr_reg(8'h62, 8'h00);
  endtask
  task automatic t_auto;
    auto_mode <= 1'b1;
    wr_reg(8'h65, 8'h11);
    rd_chk(8'h65, 8'h5a);
    below <= 3'h7;
    hold <= 3'h5;
    calc <= '{8'h33, 8'h33, 8'h33};
    repeat (3) @(posedge clk_sys);
    rd_chk(8'ha0, 8'h3c);
    rd_chk(8'ha1, 8'h00);
    rd_chk(8'ha2, 8'h78);
    below <= 3'h0;
    rd_chk(8'ha1, 8'h33);
    auto_mode <= 1'b0;
    wr_reg(8'h65, 8'h11);
    rd_chk(8'h65, 8'h11);
  endtask
  task automatic t_pwm;
    for (int i = 0; i < 4; i++) begin
      calc <= '{duties[i], duties[i], duties[i]};
      rd_chk(8'ha0, duties[i]);
      rd_chk(8'ha1, duties[i]);
      rd_chk(8'ha2, duties[i]);
      repeat (600) @(posedge clk_sys);
      for (int k = 0; k < 3; k++) begin
        chk(meas[k*9 +: 9], (i == 3) ? 9'h100 : {1'b0, duties[i]});
      end
    end
  endtask
  task automatic t_ramp(input int sel, input logic [2:0] code);
    wr_reg(8'h62, 8'h00);
    calc[sel-1] <= 8'h00;
    repeat (3) @(posedge clk_sys);
    if (sel == 2) begin
      wr_reg(8'h62, {1'b1, code, 1'b0, 3'h7 - code});
    end else begin
      wr_reg(8'h62, {1'b0, 3'h7 - code, 1'b1, code});
    end
    ramp_to(sel, 8'hc8, steps[code]);
    ramp_to(sel, 8'h07, steps[code]);
  endtask
  // ----------------------------------------
  // Main sequence and timeout
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_auto();
    t_pwm();
    for (int c = 0; c < 8; c++) begin
      t_ramp(2, 3'(c));
      t_ramp(3, 3'(c));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
